// ### board_peripheral_bus_logic.sv
// Purpose: board logic on the processor peripheral bus: decode, latches, status, resets
// Assumes: bus inputs synchronous to clock; sys_rst follows the primary bus reset
// Notes:   reads answer one cycle after the select; nvram data is not driven here
`default_nettype none
`timescale 1ns/1ps

module board_peripheral_bus_logic #(
	parameter int DATA_W = 16
) (
	input  wire logic              clock,
	input  wire logic              sys_rst,
	input  wire logic              primary_bus_reset_n,
	input  wire logic              bus_wide,
	input  wire logic              pb_sel,
	input  wire logic              pb_write,
	input  wire logic [31:0]       pb_addr,
	input  wire logic [DATA_W-1:0] pb_wdata,
	output var  logic [DATA_W-1:0] pb_rdata,
	output var  logic              pb_rdata_oe,
	output var  logic              nvram_sel,
	output var  logic [7:0]        hex_left,
	output var  logic [7:0]        hex_right,
	output var  logic              buzzer_on,
	input  wire logic [3:0]        rotary_pos,
	input  wire logic              batt_present,
	input  wire logic              batt_charged,
	input  wire logic              batt_discharged,
	output var  logic              battery_enable,
	input  wire logic              mem_cke_cpu,
	output var  logic              memory_clock_enable,
	output var  logic              board_reset_n,
	input  wire logic              debug_system_reset_n_in,
	output var  logic              debug_system_reset_n_out,
	output var  logic              debug_system_reset_n_oe
);
	// ************************************************************
	// window decode
	// ************************************************************
	function automatic logic win_hit(input logic [31:0] addr, input logic [15:0] win);
		win_hit = (addr[board_bus_pkg::ADDR_W-1:board_bus_pkg::WIN_LSB] == win);
	endfunction

	board_bus_pkg::bus_state_t st_r;
	board_bus_pkg::bus_state_t st_nxt;
	logic              take;
	logic              wr_left;
	logic              wr_right;
	logic              wr_buzzer;
	logic              wr_battery;
	logic [7:0]        batt_view;
	logic [DATA_W-1:0] wdata_eff;
	logic [DATA_W-1:0] rdata_r;
	logic [DATA_W-1:0] rdata_nxt;
	logic              oe_r;
	logic              oe_nxt;
	logic              nvram_r;
	logic              nvram_nxt;
	logic              buzzer_r;
	logic              buzzer_nxt;
	logic              bat_en_r;
	logic              bat_en_nxt;

	// one request per two cycles; a select during the answer is ignored
	assign take       = pb_sel && (st_r == board_bus_pkg::ST_IDLE);
	assign wr_left    = take && pb_write && win_hit(pb_addr, board_bus_pkg::WIN_HEX_LEFT);
	assign wr_right   = take && pb_write && win_hit(pb_addr, board_bus_pkg::WIN_HEX_RIGHT);
	assign wr_buzzer  = take && pb_write && win_hit(pb_addr, board_bus_pkg::WIN_BUZZER);
	assign wr_battery = take && pb_write && win_hit(pb_addr, board_bus_pkg::WIN_BATTERY);

	// narrow mode ignores the upper byte lane
	always_comb begin
		wdata_eff = pb_wdata;
		if (!bus_wide) begin
			wdata_eff = {{(DATA_W-board_bus_pkg::NARROW_W){1'b0}},
				pb_wdata[board_bus_pkg::NARROW_W-1:0]};
		end
	end

	assign batt_view = {board_bus_pkg::BAT_RESERVED, bat_en_r, batt_discharged,
		batt_charged, batt_present};

	// ************************************************************
	// display latches
	// ************************************************************
	// latches hold until written
	// left latch loads on its own window only
	hold_reg #(
		.WIDTH   (board_bus_pkg::HEX_W),
		.RST_VAL (board_bus_pkg::HEX_RST)
	) u_hex_left (
		.clock   (clock),
		.sys_rst (sys_rst),
		.load    (wr_left),
		.din     (wdata_eff[board_bus_pkg::HEX_W-1:0]),
		.q       (hex_left)
	);

	// right latch loads on its own window only
	hold_reg #(
		.WIDTH   (board_bus_pkg::HEX_W),
		.RST_VAL (board_bus_pkg::HEX_RST)
	) u_hex_right (
		.clock   (clock),
		.sys_rst (sys_rst),
		.load    (wr_right),
		.din     (wdata_eff[board_bus_pkg::HEX_W-1:0]),
		.q       (hex_right)
	);

	// ************************************************************
	// bus answer, buzzer, battery enable, nvram select
	// ************************************************************
	always_comb begin
		st_nxt     = board_bus_pkg::ST_IDLE;
		rdata_nxt  = '0;
		oe_nxt     = 1'b0;
		nvram_nxt  = 1'b0;
		buzzer_nxt = buzzer_r;
		bat_en_nxt = bat_en_r;
		if (sys_rst) begin
			// every register back to its reset value
			buzzer_nxt = board_bus_pkg::BUZZER_RST;
			bat_en_nxt = board_bus_pkg::BAT_ENABLE_RST;
		end else begin
			case (st_r)
				board_bus_pkg::ST_IDLE: begin
					if (take) begin
						st_nxt = board_bus_pkg::ST_ANSWER;
						// nvram select for the whole window
						nvram_nxt = win_hit(pb_addr, board_bus_pkg::WIN_NVRAM);
					end
					if (wr_buzzer) begin
						buzzer_nxt = wdata_eff[board_bus_pkg::BUZZER_BIT];
					end
					// only the enable bit is writable
					if (wr_battery) begin
						bat_en_nxt = wdata_eff[board_bus_pkg::BAT_ENABLE];
					end
					if (take && !pb_write) begin
						oe_nxt = 1'b1;
						if (win_hit(pb_addr, board_bus_pkg::WIN_BATTERY)) begin
							rdata_nxt[board_bus_pkg::BATT_W-1:0] = batt_view;
						end else if (win_hit(pb_addr, board_bus_pkg::WIN_ROTARY)) begin
							rdata_nxt[board_bus_pkg::ROTARY_W-1:0] = rotary_pos;
						end else if (win_hit(pb_addr, board_bus_pkg::WIN_HEX_LEFT)) begin
							rdata_nxt[board_bus_pkg::HEX_W-1:0] = hex_left;
						end else if (win_hit(pb_addr, board_bus_pkg::WIN_HEX_RIGHT)) begin
							rdata_nxt[board_bus_pkg::HEX_W-1:0] = hex_right;
						end else if (win_hit(pb_addr, board_bus_pkg::WIN_BUZZER)) begin
							rdata_nxt[board_bus_pkg::BUZZER_BIT] = buzzer_r;
						end else begin
							// nvram and unknown windows: leave the lane to others
							oe_nxt = 1'b0;
						end
					end
				end
				board_bus_pkg::ST_ANSWER: begin
					st_nxt = board_bus_pkg::ST_IDLE;
				end
				default: begin
					st_nxt = board_bus_pkg::ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		st_r     <= st_nxt;
		rdata_r  <= rdata_nxt;
		oe_r     <= oe_nxt;
		nvram_r  <= nvram_nxt;
		buzzer_r <= buzzer_nxt;
		bat_en_r <= bat_en_nxt;
	end

	assign pb_rdata       = rdata_r;
	assign pb_rdata_oe    = oe_r;
	assign nvram_sel      = nvram_r;
	assign buzzer_on      = buzzer_r;
	assign battery_enable = bat_en_r;

	// ************************************************************
	// resets and memory clock enable hold
	// ************************************************************
	logic hold_r;
	logic hold_nxt;
	logic cke_r;
	logic cke_nxt;
	logic brst_n_r;
	logic brst_n_nxt;
	logic dbg_oe_r;
	logic dbg_oe_nxt;

	always_comb begin
		// latch the low enable while the bus reset is active
		hold_nxt = !primary_bus_reset_n && (hold_r || !mem_cke_cpu);
		// inactive bus reset releases the hold
		cke_nxt  = mem_cke_cpu && !hold_nxt;
		// board drives the debug reset only from its own reset source
		// never from the debug pin, so the pin cannot latch itself low
		dbg_oe_nxt = !primary_bus_reset_n;
		// debugger low forces the same board reset as power-up
		brst_n_nxt = primary_bus_reset_n && debug_system_reset_n_in;
		if (sys_rst) begin
			brst_n_nxt = 1'b0;
		end
	end

	// the hold must outlive the reset itself, so sys_rst does not clear it
	always_ff @(posedge clock) begin
		hold_r   <= hold_nxt;
		cke_r    <= cke_nxt;
		brst_n_r <= brst_n_nxt;
		dbg_oe_r <= dbg_oe_nxt;
		debug_system_reset_n_out <= 1'b0;
	end

	assign memory_clock_enable     = cke_r;
	assign board_reset_n           = brst_n_r;
	assign debug_system_reset_n_oe = dbg_oe_r;

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	sequence s_read(logic [15:0] w);
		take && !pb_write && win_hit(pb_addr, w);
	endsequence

	sequence s_write(logic [15:0] w);
		take && pb_write && win_hit(pb_addr, w);
	endsequence

	a_batt_present_bit: assert property (s_read(board_bus_pkg::WIN_BATTERY) |=> pb_rdata_oe && pb_rdata[0] == $past(batt_present)) else $error("battery present bit wrong");
	a_batt_charged_bit: assert property (s_read(board_bus_pkg::WIN_BATTERY) |=> pb_rdata[1] == $past(batt_charged)) else $error("battery charged bit wrong");
	a_batt_empty_bit: assert property (s_read(board_bus_pkg::WIN_BATTERY) |=> pb_rdata[2] == $past(batt_discharged)) else $error("battery discharged bit wrong");
	a_batt_enable_write: assert property (s_write(board_bus_pkg::WIN_BATTERY) |=> battery_enable == $past(wdata_eff[3])) else $error("battery enable not written");
	a_nvram_window_sel: assert property (take |=> nvram_sel == $past(pb_addr[31:16] == 16'hCE87)) else $error("nvram select wrong");
	a_buzzer_write_set: assert property (s_write(board_bus_pkg::WIN_BUZZER) |=> buzzer_on == $past(wdata_eff[0])) else $error("buzzer not updated");
	a_hex_left_only: assert property (s_write(board_bus_pkg::WIN_HEX_LEFT) |=> hex_left == $past(wdata_eff[7:0]) && $stable(hex_right)) else $error("left hex write wrong");
	a_hex_right_only: assert property (s_write(board_bus_pkg::WIN_HEX_RIGHT) |=> hex_right == $past(wdata_eff[7:0]) && $stable(hex_left)) else $error("right hex write wrong");
	a_rotary_read_pos: assert property (s_read(board_bus_pkg::WIN_ROTARY) |=> pb_rdata_oe && pb_rdata == DATA_W'($past(rotary_pos))) else $error("rotary read wrong");
	a_narrow_upper_zero: assert property (take && !pb_write && !bus_wide |=> pb_rdata[15:8] == 8'h00) else $error("upper lane set in narrow mode");
	a_reset_clears_regs: assert property (disable iff (1'b0) sys_rst |=> !buzzer_on && !battery_enable && hex_left == 8'h00 && !board_reset_n) else $error("reset did not clear");
	a_debug_forces_reset: assert property (!debug_system_reset_n_in |=> !board_reset_n) else $error("debug reset ignored");
	// the hold outlives sys_rst, so these stay armed through it
	a_cke_hold_low: assert property (disable iff (1'b0) !primary_bus_reset_n && !mem_cke_cpu ##1 !primary_bus_reset_n |=> !memory_clock_enable) else $error("clock enable not held");
	a_cke_release: assert property (disable iff (1'b0) primary_bus_reset_n && mem_cke_cpu |=> memory_clock_enable) else $error("clock enable not released");
	a_reserved_read_zero: assert property (s_read(board_bus_pkg::WIN_BATTERY) |=> pb_rdata[7:4] == 4'h0) else $error("reserved bits not zero");
	a_latch_holds_value: assert property (!wr_left && !wr_buzzer |=> $stable(hex_left) && $stable(buzzer_on)) else $error("latch changed without write");
endmodule // board_peripheral_bus_logic

`default_nettype wire

// ### board_bus_pkg.sv
// Purpose: shared constants and the latch module of the board peripheral bus logic
// Assumes: one 40 MHz clock, synchronous active-high reset
// Notes:   address windows are picked on the upper sixteen address bits
`timescale 1ns/1ps
`default_nettype none

package board_bus_pkg;
	// ************************************************************
	// address windows, upper half of the bus address
	// ************************************************************
	localparam int          ADDR_W        = 32;
	localparam int          WIN_LSB       = 16;
	localparam logic [15:0] WIN_HEX_LEFT  = 16'hCE84;
	localparam logic [15:0] WIN_HEX_RIGHT = 16'hCE85;
	localparam logic [15:0] WIN_BUZZER    = 16'hCE86;
	localparam logic [15:0] WIN_NVRAM     = 16'hCE87;
	localparam logic [15:0] WIN_ROTARY    = 16'hCE88;
	localparam logic [15:0] WIN_BATTERY   = 16'hCE89;

	// ************************************************************
	// field layout and reset values
	// ************************************************************
	localparam int          HEX_W          = 8;
	localparam int          ROTARY_W       = 4;
	localparam int          BATT_W         = 8;
	localparam int          NARROW_W       = 8;
	localparam int          BAT_PRESENT    = 0;
	localparam int          BAT_CHARGED    = 1;
	localparam int          BAT_DISCHARGED = 2;
	localparam int          BAT_ENABLE     = 3;
	localparam int          BUZZER_BIT     = 0;
	localparam logic        BAT_ENABLE_RST = 1'b0;
	localparam logic        BUZZER_RST     = 1'b0;
	localparam logic [7:0]  HEX_RST        = 8'h00;
	localparam logic [3:0]  BAT_RESERVED   = 4'h0;

	// ************************************************************
	// bus answer state
	// ************************************************************
	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_ANSWER = 2'b01
	} bus_state_t;
endpackage

// ************************************************************
// latch that holds until the next write or reset; its q is read back on the bus
// ************************************************************
module hold_reg #(
	parameter int            WIDTH = 8,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input  wire logic             clock,
	input  wire logic             sys_rst,
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] din,
	output var  logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] q_nxt;

	always_comb begin
		q_nxt = q;
		if (sys_rst) begin
			q_nxt = RST_VAL;
		end else if (load) begin
			q_nxt = din;
		end
	end

	always_ff @(posedge clock) begin
		q <= q_nxt;
	end
endmodule // hold_reg

`default_nettype wire

// ### bus_ctrl_model.sv
// Purpose: peripheral bus controller model, one access at a time
// Assumes: an access is taken on the first edge with select high
// Notes:   released address and data lines show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none

module bus_ctrl_model (
	input  wire logic        clock,
	output var  logic        pb_sel,
	output var  logic        pb_write,
	output var  logic [31:0] pb_addr,
	output var  logic [15:0] pb_wdata,
	input  wire logic [15:0] pb_rdata,
	input  wire logic        pb_rdata_oe,
	input  wire logic        nvram_sel
);
	// ************************************************************
	// access task
	// ************************************************************
	initial begin
		pb_sel   = 1'b0;
		pb_write = 1'b0;
		pb_addr  = 32'h00000000;
		pb_wdata = 16'h0000;
	end

	// full lanes, one access per three cycles
	task automatic access(input logic wr, input logic [31:0] a, input logic [15:0] d,
		output logic [15:0] rd, output logic oe, output logic nv);
		@(posedge clock);
		pb_sel   <= 1'b1;
		pb_write <= wr;
		pb_addr  <= a;
		pb_wdata <= d;
		@(posedge clock);
		pb_sel   <= 1'b0;
		// a stale address must never look valid
		pb_addr  <= ~a;
		pb_wdata <= ~d;
		// answer stands only until the next edge, so take it mid-cycle
		@(negedge clock);
		rd = pb_rdata;
		oe = pb_rdata_oe;
		nv = nvram_sel;
		@(posedge clock);
	endtask
endmodule // bus_ctrl_model

`default_nettype wire

// ### test_board_peripheral_bus_logic.sv
// Purpose: self-checking bench of the board peripheral bus logic
// Assumes: the controller model makes every bus access
// Notes:   a reference model of the latches is compared after each access
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin mismatches++; \
	$display("mismatch %s expected %h seen %h", n, e, g); end end

module test_board_peripheral_bus_logic;
	logic        clock = 1'b0, sys_rst = 1'b1, primary_bus_reset_n = 1'b1, bus_wide = 1'b1;
	logic [3:0]  rotary_pos = 4'h0;
	logic        batt_present = 1'b0, batt_charged = 1'b0, batt_discharged = 1'b0;
	logic        mem_cke_cpu = 1'b1, dbg_drv = 1'b0, oe, nv, m_buz, m_en;
	logic [7:0]  m_left, m_right;
	logic [31:0] seed = 32'h000011FC, r, a;
	logic [15:0] rd, ex, d;
	logic [2:0]  w;
	int          mismatches = 0, check_count = 0, cycles = 0, i;
	wire logic        pb_sel, pb_write, pb_rdata_oe, nvram_sel, buzzer_on, battery_enable;
	wire logic        memory_clock_enable, board_reset_n, debug_system_reset_n_in;
	wire logic        debug_system_reset_n_out, debug_system_reset_n_oe;
	wire logic [31:0] pb_addr;
	wire logic [15:0] pb_wdata, pb_rdata;
	wire logic [7:0]  hex_left, hex_right;

	// two-way debug reset pin with pull-up
	assign debug_system_reset_n_in = ~dbg_drv & ~(debug_system_reset_n_oe & ~debug_system_reset_n_out);

	always #12.5 clock = ~clock;

	board_peripheral_bus_logic #(.DATA_W(16)) DUT (
		.clock, .sys_rst, .primary_bus_reset_n, .bus_wide, .pb_sel, .pb_write, .pb_addr,
		.pb_wdata, .pb_rdata, .pb_rdata_oe, .nvram_sel, .hex_left, .hex_right, .buzzer_on,
		.rotary_pos, .batt_present, .batt_charged, .batt_discharged, .battery_enable,
		.mem_cke_cpu, .memory_clock_enable, .board_reset_n, .debug_system_reset_n_in,
		.debug_system_reset_n_out, .debug_system_reset_n_oe
	);

	bus_ctrl_model ctrl (
		.clock, .pb_sel, .pb_write, .pb_addr, .pb_wdata, .pb_rdata, .pb_rdata_oe, .nvram_sel
	);

	// ************************************************************
	// helpers
	// ************************************************************
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction

	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic check_latches;
		`CHK("hex_left", m_left, hex_left)
		`CHK("hex_right", m_right, hex_right)
		`CHK("buzzer_on", m_buz, buzzer_on)
		`CHK("battery_enable", m_en, battery_enable)
	endtask

	// a hang counts as a failure
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			finish_test();
		end
	end

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		repeat (12) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		#1;
		{m_left, m_right, m_buz, m_en} = '0;
		check_latches();
		`CHK("board_reset_n", 1'b1, board_reset_n)
		for (i = 0; i < 300; i++) begin
			seed = xs(seed);
			r = seed;
			seed = xs(seed);
			d = seed[31:16];
			w = r[26:24];
			a = {(w == 3'd7) ? 16'h0000 : 16'hCE84 + 16'(w), seed[15:0]};
			@(posedge clock);
			{rotary_pos, batt_present, batt_charged, batt_discharged} <= r[22:16];
			bus_wide <= r[23];
			ctrl.access(r[27], a, d, rd, oe, nv);
			ex = 16'h0000;
			if (r[27]) begin
				case (w)
					3'd0: m_left = d[7:0];
					3'd1: m_right = d[7:0];
					3'd2: m_buz = d[0];
					3'd5: m_en = d[3];
					default: ;
				endcase
			end else begin
				case (w)
					3'd0: ex = {8'h00, m_left};
					3'd1: ex = {8'h00, m_right};
					3'd2: ex = {15'h0000, m_buz};
					3'd4: ex = {12'h000, r[22:19]};
					3'd5: ex = {12'h000, m_en, r[16], r[17], r[18]};
					default: ;
				endcase
			end
			`CHK("pb_rdata_oe", !r[27] && (w inside {0, 1, 2, 4, 5}), oe)
			`CHK("pb_rdata", ex, rd)
			`CHK("nvram_sel", w == 3'd3, nv)
			check_latches();
		end
		@(posedge clock);
		primary_bus_reset_n <= 1'b0;
		sys_rst <= 1'b1;
		mem_cke_cpu <= 1'b0;
		repeat (3) @(posedge clock);
		#1;
		{m_left, m_right, m_buz, m_en} = '0;
		check_latches();
		`CHK("board_reset_n", 1'b0, board_reset_n)
		`CHK("debug_oe", 1'b1, debug_system_reset_n_oe)
		`CHK("debug_out", 1'b0, debug_system_reset_n_out)
		@(posedge clock);
		mem_cke_cpu <= 1'b1;
		repeat (3) @(posedge clock);
		#1;
		`CHK("mce_hold", 1'b0, memory_clock_enable)
		@(posedge clock);
		primary_bus_reset_n <= 1'b1;
		sys_rst <= 1'b0;
		repeat (3) @(posedge clock);
		#1;
		`CHK("mce_free", 1'b1, memory_clock_enable)
		`CHK("debug_oe", 1'b0, debug_system_reset_n_oe)
		`CHK("board_reset_n", 1'b1, board_reset_n)
		@(posedge clock);
		dbg_drv <= 1'b1;
		repeat (2) @(posedge clock);
		#1;
		`CHK("board_reset_n", 1'b0, board_reset_n)
		@(posedge clock);
		dbg_drv <= 1'b0;
		repeat (2) @(posedge clock);
		#1;
		`CHK("board_reset_n", 1'b1, board_reset_n)
		finish_test();
	end
endmodule // test_board_peripheral_bus_logic

`default_nettype wire
